// ===== core/acr_top.sv
// Purpose: Converter control and result registers with Avalon-MM access.
// Assumes: Converter core delivers a 10-bit sample on every done strobe.
// Notes:   Answers one cycle after a request; waitrequest is high meanwhile.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module acr_top
    import acr_pkg::*;
#(
    parameter int SINGLE_N = SINGLE_CYCLES,   // Single-shot period
    parameter int REPEAT_N = REPEAT_CYCLES    // Repeat period
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Avalon-MM slave
    input wire logic [11:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    output logic [1:0] response_o,
    // DMA write port to control register
    input wire logic dma_wr_i,
    input wire logic [7:0] dma_data_i,
    // Converter core
    input wire logic [9:0] sample_i,
    output logic [3:0] chan_sel_o,
    output logic int_ref_en_o,
    output logic conv_busy_o,
    output logic result_valid_o,
    // Interrupt
    output logic irq_o
);
    // ==========================================================
    // Decode helpers
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    acr_core_if cif();

    logic [6:0] ctl_r;       // Control bits 6:0, go bit lives in busy
    logic [7:0] res_hi_r;    // Result upper byte
    logic [1:0] res_lo_r;    // Live low bits
    logic [1:0] res_lo_lat_r;// Low bits latched by upper-byte read
    logic valid_r;           // Result stands valid
    logic st_r;              // Sticky done status
    logic msk_r;             // Done interrupt mask
    logic ack_r;             // Answer phase of bus access
    logic [31:0] rdata_r;    // Read data register
    logic [1:0] resp_r;      // Bus response
    logic req;               // Request pending this cycle
    logic wr_take;           // Write accepted at this edge
    logic go_repeat;         // Repeat select of the starting write
    logic wr_go;             // Bus or DMA write strobes go bit
    logic wr_ctl;            // Bus write to control byte
    logic [7:0] ctl_rd;      // Control as read

    // Request in its first cycle, answered at the next edge
    assign req = (read_i | write_i) & ~ack_r;
    // A write lands at the edge where waitrequest is seen low
    assign wr_take = write_i & ack_r;
    assign wr_ctl = wr_take & byteenable_i[0] & hit(address_i, OFF_CTL);
    // Only a one starts; zero is ignored
    assign wr_go = (wr_ctl & writedata_i[CTL_GO_BIT]) |
                   (dma_wr_i & dma_data_i[CTL_GO_BIT]);
    // Mode of the conversion being started, DMA first as for control
    assign go_repeat = dma_wr_i ? dma_data_i[CTL_REPEAT_BIT] : writedata_i[CTL_REPEAT_BIT];
    assign cif.start = wr_go;
    assign cif.repeat_mode = ctl_r[CTL_REPEAT_BIT];
    // Go reads as busy, cleared by hardware at single-shot completion
    assign ctl_rd = {cif.busy, ctl_r};

    acr_seq #(.SINGLE_N(SINGLE_N), .REPEAT_N(REPEAT_N)) u_seq (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .cif(cif)
    );

    // ==========================================================
    // Control register, bus or DMA writer
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctl_r <= CTL_RESET[6:0];
        end else if (dma_wr_i) begin
            ctl_r <= dma_data_i[6:0];
        end else if (wr_ctl) begin
            // Channel, repeat, reference, reserved held as written
            ctl_r <= writedata_i[6:0];
        end
    end

    // ==========================================================
    // Result capture, no reset on data
    always_ff @(posedge clk_i) begin
        if (cif.done) begin
            // Last completed result held until next
            res_hi_r <= sample_i[9:2];
            res_lo_r <= sample_i[1:0];
        end
        if (req & read_i & hit(address_i, OFF_RES_HI)) begin
            res_lo_lat_r <= res_lo_r;
        end
    end

    // Valid flag dropped during single-shot conversion
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            valid_r <= 1'b0;
        end else if (cif.start & ~go_repeat) begin
            // A new single shot wins over a completion in the same cycle
            valid_r <= 1'b0;
        end else if (cif.done) begin
            // A repeat start leaves the last result standing
            valid_r <= 1'b1;
        end
    end

    // ==========================================================
    // Interrupt status and mask, set wins over clear
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= 1'b0;
            msk_r <= 1'b0;
        end else begin
            if (cif.done) begin
                st_r <= 1'b1;
            end else if (wr_take & byteenable_i[0] & hit(address_i, OFF_IRQ_ST) & writedata_i[IRQ_DONE_BIT]) begin
                st_r <= 1'b0;
            end
            if (wr_take & byteenable_i[0] & hit(address_i, OFF_IRQ_MSK)) begin
                msk_r <= writedata_i[IRQ_DONE_BIT];
            end
        end
    end

    // ==========================================================
    // Bus answer, one wait cycle per access
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            resp_r <= 2'h0;
        end else begin
            ack_r <= req;
            if (req) begin
                resp_r <= 2'h0;
                unique case (1'b1)
                    hit(address_i, OFF_CTL): rdata_r <= {24'h000000, ctl_rd};
                    // Full result is upper byte then latched 7:6
                    hit(address_i, OFF_RES_HI): rdata_r <= {24'h000000, res_hi_r};
                    hit(address_i, OFF_RES_LO): rdata_r <= {24'h000000, res_lo_lat_r, 6'h00};
                    hit(address_i, OFF_IRQ_ST): rdata_r <= {31'h0, st_r};
                    hit(address_i, OFF_IRQ_MSK): rdata_r <= {31'h0, msk_r};
                    default: begin
                        rdata_r <= BAD_ADDR_DATA;
                        resp_r <= 2'h2;
                    end
                endcase
            end
        end
    end

    assign waitrequest_o = (read_i | write_i) & ~ack_r;
    assign readdata_o = rdata_r;
    assign response_o = resp_r;
    assign chan_sel_o = ctl_r[CTL_CHAN_MSB:0];
    assign int_ref_en_o = ~ctl_r[CTL_VREF_BIT];
    assign conv_busy_o = cif.busy;
    assign result_valid_o = valid_r;
    assign irq_o = st_r & msk_r;

    // ==========================================================
    // Assertions
    // Go starts the sequencer at the next edge
    property p_start_busy;
        @(posedge clk_i) disable iff (!arst_n_i) cif.start |=> cif.busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("go did not start");
    // A restart never reports the abandoned conversion
    property p_restart;
        @(posedge clk_i) disable iff (!arst_n_i) (cif.busy && cif.start) |=> !cif.done;
    endproperty
    a_restart: assert property (p_restart) else $error("restart finished early");
    // Single-shot completion clears the go bit
    property p_go_clear;
        @(posedge clk_i) disable iff (!arst_n_i)
            (cif.done && !ctl_r[CTL_REPEAT_BIT] && !cif.start) |=> !ctl_rd[CTL_GO_BIT];
    endproperty
    a_go_clear: assert property (p_go_clear) else $error("go not cleared");
    // Go bit read back follows the running conversion
    property p_go_read;
        @(posedge clk_i) disable iff (!arst_n_i)
            (req && read_i && hit(address_i, OFF_CTL)) |=> readdata_o[CTL_GO_BIT] == $past(cif.busy);
    endproperty
    a_go_read: assert property (p_go_read) else $error("go read back wrong");
    // Nothing but go wakes the sequencer
    property p_zero_noop;
        @(posedge clk_i) disable iff (!arst_n_i) (!cif.busy && !wr_go) |=> !cif.busy;
    endproperty
    a_zero_noop: assert property (p_zero_noop) else $error("busy without go");
    // A control write with go zero never restarts
    property p_zero_write;
        @(posedge clk_i) disable iff (!arst_n_i)
            (wr_ctl && !writedata_i[CTL_GO_BIT] && !dma_wr_i) |-> !cif.start;
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("go zero restarted");
    // Reference enable follows the written select bit
    property p_vref;
        @(posedge clk_i) disable iff (!arst_n_i)
            (wr_ctl && !dma_wr_i) |=> int_ref_en_o == !$past(writedata_i[CTL_VREF_BIT]);
    endproperty
    a_vref: assert property (p_vref) else $error("reference select wrong");
    // Channel field follows the bus write
    property p_chan;
        @(posedge clk_i) disable iff (!arst_n_i)
            (wr_ctl && !dma_wr_i) |=> chan_sel_o == $past(writedata_i[CTL_CHAN_MSB:0]);
    endproperty
    a_chan: assert property (p_chan) else $error("channel select wrong");
    // Repeat select follows the bus write
    property p_repeat_sel;
        @(posedge clk_i) disable iff (!arst_n_i)
            (wr_ctl && !dma_wr_i) |=> cif.repeat_mode == $past(writedata_i[CTL_REPEAT_BIT]);
    endproperty
    a_repeat_sel: assert property (p_repeat_sel) else $error("repeat select wrong");
    // Every bus access gets its answer one cycle later
    property p_answer;
        @(posedge clk_i) disable iff (!arst_n_i) (read_i || write_i) && waitrequest_o |=> !waitrequest_o;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    // Upper byte takes the eight top bits of the sample
    property p_capture;
        @(posedge clk_i) disable iff (!arst_n_i) cif.done |=> res_hi_r == $past(sample_i[9:2]);
    endproperty
    a_capture: assert property (p_capture) else $error("upper byte capture wrong");
    // Upper byte read returns the stored byte
    property p_res_read;
        @(posedge clk_i) disable iff (!arst_n_i)
            (valid_r && req && read_i && hit(address_i, OFF_RES_HI)) |=> readdata_o[7:0] == $past(res_hi_r);
    endproperty
    a_res_read: assert property (p_res_read) else $error("upper byte read wrong");
    // A write to the upper byte leaves it alone
    property p_res_ro;
        @(posedge clk_i) disable iff (!arst_n_i)
            (valid_r && wr_take && hit(address_i, OFF_RES_HI) && !cif.done) |=> $stable(res_hi_r);
    endproperty
    a_res_ro: assert property (p_res_ro) else $error("upper byte written");
    // Low bits read returns the latched pair in bits 7:6
    property p_lo_read;
        @(posedge clk_i) disable iff (!arst_n_i)
            (req && read_i && hit(address_i, OFF_RES_LO)) |=> readdata_o[7:6] == $past(res_lo_lat_r);
    endproperty
    a_lo_read: assert property (p_lo_read) else $error("low bits read wrong");
    // Upper byte read latches the matching low bits
    property p_latch;
        @(posedge clk_i) disable iff (!arst_n_i)
            (req && read_i && hit(address_i, OFF_RES_HI)) |=> res_lo_lat_r == $past(res_lo_r);
    endproperty
    a_latch: assert property (p_latch) else $error("low bits not latched");
    // A single-shot start withdraws the result
    property p_invalid;
        @(posedge clk_i) disable iff (!arst_n_i) (cif.start && !go_repeat) |=> !valid_r;
    endproperty
    a_invalid: assert property (p_invalid) else $error("valid in single shot");
    // A valid result holds until the next completion
    property p_hold;
        @(posedge clk_i) disable iff (!arst_n_i) (valid_r && !cif.done) |=> $stable(res_hi_r);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed");
    // A completion without a single-shot start in the same cycle leaves a valid result
    property p_valid_set;
        @(posedge clk_i) disable iff (!arst_n_i)
            (cif.done && !(cif.start && !go_repeat)) |=> valid_r;
    endproperty
    a_valid_set: assert property (p_valid_set) else $error("result not valid");
    // DMA writes reach the channel field
    property p_dma_ctl;
        @(posedge clk_i) disable iff (!arst_n_i) dma_wr_i |=> chan_sel_o == $past(dma_data_i[CTL_CHAN_MSB:0]);
    endproperty
    a_dma_ctl: assert property (p_dma_ctl) else $error("DMA channel wrong");
    // DMA go starts a conversion
    property p_dma_go;
        @(posedge clk_i) disable iff (!arst_n_i) (dma_wr_i && dma_data_i[CTL_GO_BIT]) |=> cif.busy;
    endproperty
    a_dma_go: assert property (p_dma_go) else $error("DMA go ignored");
    // After each done the sequencer runs on only in repeat mode
    property p_reload;
        @(posedge clk_i) disable iff (!arst_n_i) cif.done |-> cif.busy == $past(cif.repeat_mode);
    endproperty
    a_reload: assert property (p_reload) else $error("reload after done wrong");
    // Main scenarios reached by the bench
    c_conv: cover property (@(posedge clk_i) cif.done);
    c_restart: cover property (@(posedge clk_i) cif.busy && cif.start);
    c_irq: cover property (@(posedge clk_i) irq_o);
    c_dma_go: cover property (@(posedge clk_i) dma_wr_i && dma_data_i[CTL_GO_BIT]);
    c_repeat: cover property (@(posedge clk_i) cif.done && cif.repeat_mode);
endmodule : acr_top

// ===== core/acr_pkg.sv
// Purpose: Shared constants for the converter control and result block.
// Assumes: Avalon-MM slave with 32-bit data, byte addresses.
// Notes:   Offsets are byte addresses, one register per byte address.
package acr_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [11:0] OFF_CTL = 12'hF70;      // Converter control
    localparam logic [11:0] OFF_RES_HI = 12'hF72;   // Result upper byte
    localparam logic [11:0] OFF_RES_LO = 12'hF73;   // Result lower bits
    localparam logic [11:0] OFF_IRQ_ST = 12'hF74;   // Interrupt status
    localparam logic [11:0] OFF_IRQ_MSK = 12'hF75;  // Interrupt mask
    localparam logic [11:0] OFF_DMA_PORT = 12'hF76; // DMA write port to control
    // ==========================================================
    // Control field positions
    localparam int CTL_GO_BIT = 7;
    localparam int CTL_RSVD_BIT = 6;
    localparam int CTL_VREF_BIT = 5;
    localparam int CTL_REPEAT_BIT = 4;
    localparam int CTL_CHAN_MSB = 3;
    // Reset value of control register
    localparam logic [7:0] CTL_RESET = 8'h00;
    // Status bit positions
    localparam int IRQ_DONE_BIT = 0;
    // ==========================================================
    // Timing counts in system clocks
    localparam int SINGLE_CYCLES = 5129;
    localparam int REPEAT_CYCLES = 256;
    localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;
endpackage : acr_pkg

// ===== core/acr_core_if.sv
// Purpose: Link between register front end and conversion sequencer.
// Assumes: Single clock domain.
// Notes:   Start is a one-cycle pulse; done is a one-cycle pulse.
`timescale 1ns/1ps
interface acr_core_if;
    logic start;        // Start or restart a conversion
    logic repeat_mode;  // Repeat conversion select
    logic busy;         // Conversion in progress
    logic done;         // Conversion finished
    modport ctl (output start, output repeat_mode, input busy, input done);
    modport seq (input start, input repeat_mode, output busy, output done);
endinterface : acr_core_if

// ===== core/acr_seq.sv
// Purpose: Conversion sequencer counting the conversion period.
// Assumes: Start pulse restarts any running conversion.
// Notes:   Repeat mode reruns until software selects single shot.
`timescale 1ns/1ps
module acr_seq
    import acr_pkg::*;
#(
    parameter int SINGLE_N = SINGLE_CYCLES,
    parameter int REPEAT_N = REPEAT_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Link to front end
    acr_core_if.seq cif
);
    // ==========================================================
    // Period counter
    logic [15:0] cnt_r;   // Cycles remaining
    logic busy_r;         // Conversion running
    logic done_r;         // One-cycle completion strobe

    // Counter and busy state
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= 16'h0000;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (cif.start) begin
                // Abandon and restart from the beginning
                cnt_r <= 16'(SINGLE_N - 1);
                busy_r <= 1'b1;
            end else if (busy_r) begin
                if (cnt_r == 16'h0000) begin
                    // Each conversion not abandoned by a restart ends with a done strobe
                    done_r <= 1'b1;
                    busy_r <= cif.repeat_mode;
                    cnt_r <= 16'(REPEAT_N - 1);
                end else begin
                    cnt_r <= cnt_r - 16'h0001;
                end
            end
        end
    end

    assign cif.busy = busy_r;
    assign cif.done = done_r;
endmodule : acr_seq

// ===== testbench/acr_conv_model.sv
// Purpose: Behavioural converter core feeding samples to the control block.
// Assumes: Sample follows the selected channel and reference at once.
// Notes:   No analog behaviour; the pattern is chosen to be easy to predict.
`timescale 1ns/1ps
module acr_conv_model
    import acr_pkg::*;
(
    // Selection from the control block
    input wire logic [3:0] chan_i,
    input wire logic int_ref_en_i,
    // Sample towards the control block
    output logic [9:0] sample_o
);
    // ==========================================================
    // Sample pattern
    // Channel on top, external reference flag next, fixed tail
    assign sample_o = {chan_i, ~int_ref_en_i, 5'h15};
endmodule : acr_conv_model

// ===== testbench/adc_control_and_result_regs_tb.sv
// Purpose: Self-checking bench for the converter control and result block.
// Assumes: Short conversion periods set by parameter.
// Notes:   All bus cycles go through one Avalon-MM master task.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end
module adc_control_and_result_regs_tb
    import acr_pkg::*;
;
    localparam int SN = 20; // Short single-shot period
    localparam int RN = 8; // Short repeat period
    logic clk_i, arst_n_i, read_i, write_i, dma_wr_i; // Driven inputs
    logic [11:0] address_i;
    logic [31:0] writedata_i, readdata_o, q;
    logic [3:0] byteenable_i, chan_sel_o;
    logic [7:0] dma_data_i;
    logic [9:0] sample_i;
    logic [1:0] response_o, rsp;
    logic waitrequest_o, int_ref_en_o, conv_busy_o, result_valid_o, irq_o;
    int error_cnt = 0; // Mismatches
    int tests_run = 0; // Comparisons
    int c; // Cycle counter
    acr_top #(.SINGLE_N(SN), .REPEAT_N(RN)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .response_o(response_o), .dma_wr_i(dma_wr_i), .dma_data_i(dma_data_i),
        .sample_i(sample_i), .chan_sel_o(chan_sel_o), .int_ref_en_o(int_ref_en_o),
        .conv_busy_o(conv_busy_o), .result_valid_o(result_valid_o), .irq_o(irq_o));
    acr_conv_model u_conv (.chan_i(chan_sel_o), .int_ref_en_i(int_ref_en_o), .sample_o(sample_i));
    // Expected sample for a channel and reference flag
    function automatic logic [9:0] smp(input logic [3:0] ch, input logic ext);
        return {ch, ext, 5'h15};
    endfunction : smp
    // Verdict and end of run
    task automatic complete_run();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    // One bus cycle; held until waitrequest is sampled low
    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address_i <= a;
        writedata_i <= d;
        write_i <= wr;
        read_i <= !wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 50);
        q = readdata_o;
        rsp = response_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            complete_run();
        end
        @(posedge clk_i);
    endtask : acc
    // Bounded wait until the conversion ends; counts cycles
    task automatic wait_idle();
        c = 0;
        while (conv_busy_o !== 1'b0 && c < 200) begin
            @(posedge clk_i);
            c++;
        end
        if (c >= 200) begin
            error_cnt++;
            complete_run();
        end
    endtask : wait_idle
    // ==========================================================
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // ==========================================================
    // Main sequence; reserved bit six is always written zero
    initial begin
        {arst_n_i, read_i, write_i, dma_wr_i, address_i, writedata_i, dma_data_i} = '0;
        byteenable_i = 4'hF;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        acc(1'b0, OFF_CTL, 32'h0);
        `CHK("ctl_reset", CTL_RESET, q[7:0])
        `CHK("ref_reset", 1'b1, int_ref_en_o)
        acc(1'b1, OFF_CTL, 32'h0000_0025);
        `CHK("chan_sel", 4'h5, chan_sel_o)
        `CHK("ref_ext", 1'b0, int_ref_en_o)
        acc(1'b1, OFF_CTL, 32'h0000_00A5);
        acc(1'b0, OFF_CTL, 32'h0);
        `CHK("go_busy", 8'hA5, q[7:0])
        `CHK("valid_low", 1'b0, result_valid_o)
        acc(1'b1, OFF_CTL, 32'h0000_0025);
        `CHK("go_zero", 1'b1, conv_busy_o)
        wait_idle();
        acc(1'b0, OFF_CTL, 32'h0);
        `CHK("go_clear", 8'h25, q[7:0])
        acc(1'b0, OFF_RES_HI, 32'h0);
        `CHK("res_hi", smp(4'h5, 1'b1), {q[7:0], 2'b00} | 10'h015)
        acc(1'b0, OFF_RES_LO, 32'h0);
        `CHK("res_lo", 2'b01, q[7:6])
        acc(1'b1, OFF_RES_HI, 32'h0000_0000);
        acc(1'b0, OFF_RES_HI, 32'h0);
        `CHK("res_ro", 8'(smp(4'h5, 1'b1) >> 2), q[7:0])
        acc(1'b0, OFF_IRQ_ST, 32'h0);
        `CHK("st_done", 1'b1, q[IRQ_DONE_BIT])
        `CHK("irq_masked", 1'b0, irq_o)
        acc(1'b1, OFF_IRQ_MSK, 32'h0000_0001);
        `CHK("irq_on", 1'b1, irq_o)
        acc(1'b1, OFF_IRQ_ST, 32'h0000_0001);
        `CHK("irq_clr", 1'b0, irq_o)
        acc(1'b1, OFF_IRQ_MSK, 32'h0000_0000);
        acc(1'b1, OFF_CTL, 32'h0000_0081);
        repeat (10) @(posedge clk_i);
        acc(1'b1, OFF_CTL, 32'h0000_0081);
        wait_idle();
        `CHK("restart", 1'b1, c > SN - 8)
        @(posedge clk_i);
        dma_wr_i <= 1'b1;
        dma_data_i <= 8'h83;
        @(posedge clk_i);
        dma_wr_i <= 1'b0;
        @(posedge clk_i);
        `CHK("dma_go", 1'b1, conv_busy_o)
        `CHK("dma_chan", 4'h3, chan_sel_o)
        `CHK("dma_invalid", 1'b0, result_valid_o)
        wait_idle();
        acc(1'b0, OFF_RES_HI, 32'h0);
        `CHK("dma_res", smp(4'h3, 1'b0) >> 2, {2'b00, q[7:0]})
        acc(1'b1, OFF_CTL, 32'h0000_0092);
        `CHK("rep_keep", 1'b1, result_valid_o)
        repeat (SN + RN + 3) @(posedge clk_i);
        `CHK("rep_valid", 1'b1, result_valid_o)
        acc(1'b0, OFF_RES_HI, 32'h0);
        `CHK("rep_res", smp(4'h2, 1'b0) >> 2, {2'b00, q[7:0]})
        acc(1'b1, OFF_CTL, 32'h0000_0002);
        wait_idle();
        acc(1'b0, 12'h000, 32'h0);
        `CHK("bad_data", BAD_ADDR_DATA, q)
        `CHK("bad_rsp", 2'b10, rsp)
        complete_run();
    end
endmodule : adc_control_and_result_regs_tb
